// file: cvcfg_map.svh
// Purpose: Register indexes, field positions and reset values of the converter configuration bank.
// Assumes: Included by its bare name wherever the map is needed.
// Notes: The byte address of a register on the bus is four times its index.
`ifndef CVCFG_MAP_SVH
`define CVCFG_MAP_SVH

`define CVCFG_ADDR_W 12
`define CVCFG_IDX_W 10
`define CVCFG_ADDR(idx) {idx, 2'b00}

`define CVCFG_IDX_FS_A 10'h030
`define CVCFG_IDX_FS_B 10'h032
`define CVCFG_IDX_REF 10'h038
`define CVCFG_IDX_STAMP 10'h03B
`define CVCFG_IDX_SWING 10'h048
`define CVCFG_IDX_ROUTE 10'h060

`define CVCFG_NREG 6
`define CVCFG_WIDE_W 16
`define CVCFG_BYTE_W 8

`define CVCFG_RST_FS 16'hA000
`define CVCFG_RST_ZERO 16'h0000
`define CVCFG_RST_ROUTE 16'h0001

`define CVCFG_BIT_BYPASS 0
`define CVCFG_BIT_RECV_ON 0
`define CVCFG_BIT_DC_MODE 1
`define CVCFG_SWING_HI 1
`define CVCFG_SWING_LO 0
`define CVCFG_BIT_SWAP 4
`define CVCFG_PICK_HI 1
`define CVCFG_PICK_LO 0
`define CVCFG_PICK_A 2'h1
`define CVCFG_PICK_B 2'h2

`endif

// file: cvcfg_pkg.sv
// Purpose: Types shared by the converter configuration bank.
// Assumes: Numeric map lives in cvcfg_map.svh.
// Notes: Nothing here holds logic.
package cvcfg_pkg;

  typedef enum logic [2:0] {
    CVCFG_SEL_FS_A = 3'b000,
    CVCFG_SEL_FS_B = 3'b001,
    CVCFG_SEL_REF = 3'b010,
    CVCFG_SEL_STAMP = 3'b011,
    CVCFG_SEL_SWING = 3'b100,
    CVCFG_SEL_ROUTE = 3'b101,
    CVCFG_SEL_NONE = 3'b111
  } cvcfg_sel_e;

  typedef enum logic [1:0] {
    CVCFG_SWING_HIGH = 2'b00,
    CVCFG_SWING_LOW = 2'b01,
    CVCFG_SWING_RSVD = 2'b10,
    CVCFG_SWING_HIGHZ = 2'b11
  } cvcfg_swing_e;

  typedef enum logic {
    CVCFG_PH_IDLE = 1'b0,
    CVCFG_PH_ACCESS = 1'b1
  } cvcfg_phase_e;

  typedef struct packed {
    logic [15:0] full_scale_code_a;
    logic [15:0] full_scale_code_b;
    logic reference_bypass;
    logic stamp_receiver_on;
    logic stamp_dc_coupled_mode;
    cvcfg_swing_e swing_mode;
    logic chan_a_takes_b;
    logic chan_b_takes_b;
  } cvcfg_cfg_s;

  typedef struct packed {
    cvcfg_phase_e phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    cvcfg_cfg_s cfg;
  } cvcfg_state_s;

endpackage

// file: cvcfg_reg_cell.sv
// Purpose: One read/write storage register of the configuration bank.
// Assumes: Write enable is a one-cycle pulse at the bus commit edge.
// Notes: Every bit, reserved ones included, stores what is written.
`timescale 1ns/100ps
`default_nettype none
module cvcfg_reg_cell #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Write port
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // Stored value
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] val;
  } cvcfg_cell_s;

  cvcfg_cell_s st_r;
  cvcfg_cell_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (wr_en)
    begin
      st_nxt.val = wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.val;
endmodule // cvcfg_reg_cell
`default_nettype wire

// file: cvcfg_top.sv
// Purpose: APB-reached configuration register bank of a dual-input sampling converter.
// Assumes: APB master keeps the protocol; interleave_mode_on comes from the mode logic elsewhere.
// Notes: Zero wait states; configuration outputs follow the stored registers one cycle later.
//
// Behaviour
// - Input A full-scale code, 16 bits read/write, resets to A000.
// - Input B full-scale code, 16 bits read/write, resets to A000.
// - Reference bypass bit 0, resets to zero, selects core supply as reference.
// - Stamp control bit 0 enables the timestamp receiver, resets to zero.
// - Stamp control bit 1 selects DC-coupled low-voltage PECL mode, resets to zero.
// - Swing field bits 1-0: 0 high swing, 1 low swing, 3 high-Z load.
// - Input swap bit 4 matters only outside interleave mode, resets to zero.
// - Swap clear: A takes input A, B takes B; set: crossed.
// - Routing register resets to 01, reserved bits reset to zero.
// - Pick field bits 1-0 in interleave: 1 input A, 2 input B.
`timescale 1ns/100ps
`default_nettype none
`include "cvcfg_map.svh"
module cvcfg_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CVCFG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Operating mode
  input wire logic interleave_mode_on,
  // Configuration to the converter
  output cvcfg_pkg::cvcfg_cfg_s cfg
);

  function automatic cvcfg_pkg::cvcfg_sel_e decode(input logic [`CVCFG_ADDR_W-1:0] a);
    case (a)
      `CVCFG_ADDR(`CVCFG_IDX_FS_A): decode = cvcfg_pkg::CVCFG_SEL_FS_A;
      `CVCFG_ADDR(`CVCFG_IDX_FS_B): decode = cvcfg_pkg::CVCFG_SEL_FS_B;
      `CVCFG_ADDR(`CVCFG_IDX_REF): decode = cvcfg_pkg::CVCFG_SEL_REF;
      `CVCFG_ADDR(`CVCFG_IDX_STAMP): decode = cvcfg_pkg::CVCFG_SEL_STAMP;
      `CVCFG_ADDR(`CVCFG_IDX_SWING): decode = cvcfg_pkg::CVCFG_SEL_SWING;
      `CVCFG_ADDR(`CVCFG_IDX_ROUTE): decode = cvcfg_pkg::CVCFG_SEL_ROUTE;
      default: decode = cvcfg_pkg::CVCFG_SEL_NONE;
    endcase
  endfunction

  function automatic int reg_width(input int i);
    if (i < 2)
    begin
      reg_width = `CVCFG_WIDE_W;
    end
    else
    begin
      reg_width = `CVCFG_BYTE_W;
    end
  endfunction

  function automatic logic [15:0] reg_rst(input int i);
    case (i)
      0: reg_rst = `CVCFG_RST_FS;
      1: reg_rst = `CVCFG_RST_FS;
      5: reg_rst = `CVCFG_RST_ROUTE;
      default: reg_rst = `CVCFG_RST_ZERO;
    endcase
  endfunction

  localparam cvcfg_pkg::cvcfg_state_s ST_RST = '{
    phase: cvcfg_pkg::CVCFG_PH_IDLE,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h00000000,
    cfg: '{
      full_scale_code_a: `CVCFG_RST_FS,
      full_scale_code_b: `CVCFG_RST_FS,
      reference_bypass: 1'b0,
      stamp_receiver_on: 1'b0,
      stamp_dc_coupled_mode: 1'b0,
      swing_mode: cvcfg_pkg::CVCFG_SWING_HIGH,
      chan_a_takes_b: 1'b0,
      chan_b_takes_b: 1'b1
    }
  };

  cvcfg_pkg::cvcfg_state_s st_r;
  cvcfg_pkg::cvcfg_state_s st_nxt;
  cvcfg_pkg::cvcfg_sel_e sel;
  logic [2:0] sel_code;
  logic commit;
  logic [15:0] q [`CVCFG_NREG];

  assign sel = decode(paddr);
  assign sel_code = sel;
  // A transfer takes effect only at the edge where the access phase sees pready high.
  assign commit = (st_r.phase == cvcfg_pkg::CVCFG_PH_ACCESS) && st_r.pready && psel && penable;

  // Reserved bits are kept as read/write storage so that reads echo what was written to each register's 16 or 8 stored bits.
  generate
    for (genvar g = 0; g < `CVCFG_NREG; g++)
    begin : g_reg
      localparam int W = reg_width(g);
      localparam logic [15:0] R = reg_rst(g);
      logic [W-1:0] cq;
      cvcfg_reg_cell #(
        .W(W),
        .RST(R[W-1:0])
      ) u_cell (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wr_en(commit && pwrite && (sel_code == 3'(g))),
        .wr_data(pwdata[W-1:0]),
        .q(cq)
      );
      assign q[g] = 16'(cq);
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    case (st_r.phase)
      cvcfg_pkg::CVCFG_PH_IDLE:
      begin
        st_nxt.pready = 1'b0;
        if (psel && !penable)
        begin
          st_nxt.phase = cvcfg_pkg::CVCFG_PH_ACCESS;
          st_nxt.pready = 1'b1;
          st_nxt.pslverr = (sel == cvcfg_pkg::CVCFG_SEL_NONE);
          st_nxt.prdata = 32'h00000000;
          if (!pwrite && (sel != cvcfg_pkg::CVCFG_SEL_NONE))
          begin
            st_nxt.prdata = 32'(q[sel_code]);
          end
        end
      end
      cvcfg_pkg::CVCFG_PH_ACCESS:
      begin
        if (psel && penable)
        begin
          st_nxt.phase = cvcfg_pkg::CVCFG_PH_IDLE;
          st_nxt.pready = 1'b0;
          st_nxt.pslverr = 1'b0;
          st_nxt.prdata = 32'h00000000;
        end
      end
      default:
      begin
        st_nxt.phase = cvcfg_pkg::CVCFG_PH_IDLE;
        st_nxt.pready = 1'b0;
      end
    endcase

    st_nxt.cfg.full_scale_code_a = q[0];
    st_nxt.cfg.full_scale_code_b = q[1];
    st_nxt.cfg.reference_bypass = q[2][`CVCFG_BIT_BYPASS];
    st_nxt.cfg.stamp_receiver_on = q[3][`CVCFG_BIT_RECV_ON];
    st_nxt.cfg.stamp_dc_coupled_mode = q[3][`CVCFG_BIT_DC_MODE];
    st_nxt.cfg.swing_mode = cvcfg_pkg::cvcfg_swing_e'(q[4][`CVCFG_SWING_HI:`CVCFG_SWING_LO]);
    if (!interleave_mode_on)
    begin
      st_nxt.cfg.chan_a_takes_b = q[5][`CVCFG_BIT_SWAP];
      st_nxt.cfg.chan_b_takes_b = !q[5][`CVCFG_BIT_SWAP];
    end
    else if (q[5][`CVCFG_PICK_HI:`CVCFG_PICK_LO] == `CVCFG_PICK_A)
    begin
      st_nxt.cfg.chan_a_takes_b = 1'b0;
      st_nxt.cfg.chan_b_takes_b = 1'b0;
    end
    else if (q[5][`CVCFG_PICK_HI:`CVCFG_PICK_LO] == `CVCFG_PICK_B)
    begin
      st_nxt.cfg.chan_a_takes_b = 1'b1;
      st_nxt.cfg.chan_b_takes_b = 1'b1;
    end
    // A reserved pick leaves the routing as it was, so the sampler never sees a glitch.
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign prdata = st_r.prdata;
  assign cfg = st_r.cfg;

  // Helper that marks the first edge after reset release.
  logic seen_r;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seen_r <= 1'b0;
    end
    else
    begin
      seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  property p_fs_a_write;
    commit && pwrite && (sel == cvcfg_pkg::CVCFG_SEL_FS_A)
      |-> ##2 cfg.full_scale_code_a == $past(pwdata[15:0], 2);
  endproperty
  a_fs_a_write: assert property (p_fs_a_write) else $error("Full-scale A did not follow the write.");

  property p_fs_b_write;
    commit && pwrite && (sel == cvcfg_pkg::CVCFG_SEL_FS_B)
      |-> ##2 cfg.full_scale_code_b == $past(pwdata[15:0], 2);
  endproperty
  a_fs_b_write: assert property (p_fs_b_write) else $error("Full-scale B did not follow the write.");

  property p_bypass_write;
    commit && pwrite && (sel == cvcfg_pkg::CVCFG_SEL_REF)
      |-> ##2 cfg.reference_bypass == $past(pwdata[0], 2);
  endproperty
  a_bypass_write: assert property (p_bypass_write) else $error("Reference bypass did not follow the write.");

  property p_recv_write;
    commit && pwrite && (sel == cvcfg_pkg::CVCFG_SEL_STAMP)
      |-> ##2 cfg.stamp_receiver_on == $past(pwdata[0], 2);
  endproperty
  a_recv_write: assert property (p_recv_write) else $error("Stamp receiver enable wrong.");

  property p_dc_write;
    commit && pwrite && (sel == cvcfg_pkg::CVCFG_SEL_STAMP)
      |-> ##2 cfg.stamp_dc_coupled_mode == $past(pwdata[1], 2);
  endproperty
  a_dc_write: assert property (p_dc_write) else $error("Stamp coupling mode wrong.");

  property p_swing_write;
    commit && pwrite && (sel == cvcfg_pkg::CVCFG_SEL_SWING)
      |-> ##2 cfg.swing_mode == $past(pwdata[1:0], 2);
  endproperty
  a_swing_write: assert property (p_swing_write) else $error("Swing mode did not follow the write.");

  property p_dual_route;
    seen_r && !interleave_mode_on
      |=> (cfg.chan_a_takes_b == $past(q[5][`CVCFG_BIT_SWAP])) && (cfg.chan_b_takes_b != $past(q[5][`CVCFG_BIT_SWAP]));
  endproperty
  a_dual_route: assert property (p_dual_route) else $error("Dual-channel routing wrong.");

  property p_swap_ignored;
    seen_r && interleave_mode_on && $stable(interleave_mode_on) && $stable(q[5][1:0]) && $changed(q[5][4])
      |=> $stable(cfg.chan_a_takes_b);
  endproperty
  a_swap_ignored: assert property (p_swap_ignored) else $error("Swap bit acted in interleave mode.");

  property p_pick_route;
    seen_r && interleave_mode_on && (q[5][1:0] == `CVCFG_PICK_A || q[5][1:0] == `CVCFG_PICK_B)
      |=> (cfg.chan_a_takes_b == ($past(q[5][1:0]) == 2'h2)) && (cfg.chan_b_takes_b == cfg.chan_a_takes_b);
  endproperty
  a_pick_route: assert property (p_pick_route) else $error("Single-channel pick wrong.");

  property p_route_reset;
    !seen_r |-> (q[5] == `CVCFG_RST_ROUTE) && (q[0] == `CVCFG_RST_FS) && (q[4] == `CVCFG_RST_ZERO);
  endproperty
  a_route_reset: assert property (p_route_reset) else $error("Reset values wrong after release.");

  property p_read_back;
    commit && !pwrite && (sel != cvcfg_pkg::CVCFG_SEL_NONE)
      |-> (prdata == 32'(q[sel_code])) && !pslverr;
  endproperty
  a_read_back: assert property (p_read_back) else $error("Read data does not match the register.");

  property p_one_wait;
    psel && !penable && (st_r.phase == cvcfg_pkg::CVCFG_PH_IDLE) |=> pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("Access phase not answered in one cycle.");

  // The check runs only at the first edge after release, while the registers still hold their reset values.
  property p_reset_rest;
    !seen_r |-> (q[1] == `CVCFG_RST_FS) && (q[2] == `CVCFG_RST_ZERO) && (q[3] == `CVCFG_RST_ZERO);
  endproperty
  a_reset_rest: assert property (p_reset_rest) else $error("Other reset values wrong after release.");

  property p_unmapped_err;
    psel && !penable && (st_r.phase == cvcfg_pkg::CVCFG_PH_IDLE) && (sel == cvcfg_pkg::CVCFG_SEL_NONE)
      |=> pready && pslverr && (prdata == 32'h00000000);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("Unmapped access not flagged.");

  property p_unmapped_keep;
    commit && (sel == cvcfg_pkg::CVCFG_SEL_NONE)
      |=> $stable(q[0]) && $stable(q[1]) && $stable(q[2]) && $stable(q[3]) && $stable(q[4]) && $stable(q[5]);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep) else $error("Unmapped write changed a register.");

  property p_write_zero;
    psel && !penable && (st_r.phase == cvcfg_pkg::CVCFG_PH_IDLE) && pwrite |=> prdata == 32'h00000000;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("Write access returned nonzero read data.");

  property p_access_end;
    commit |=> !pready && !pslverr && (prdata == 32'h00000000);
  endproperty
  a_access_end: assert property (p_access_end) else $error("Bus answer did not fall after the access.");

  property p_fs_hold;
    seen_r && $stable(q[0]) && $stable(q[1])
      |=> $stable(cfg.full_scale_code_a) && $stable(cfg.full_scale_code_b);
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("Full-scale code moved without a write.");

  property p_ctl_hold;
    seen_r && $stable(q[2]) && $stable(q[3])
      |=> $stable(cfg.reference_bypass) && $stable(cfg.stamp_receiver_on) && $stable(cfg.stamp_dc_coupled_mode);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("Control bit moved without a write.");

  property p_swing_hold;
    seen_r && $stable(q[4]) |=> $stable(cfg.swing_mode);
  endproperty
  a_swing_hold: assert property (p_swing_hold) else $error("Swing mode moved without a write.");

  // A reserved pick must not disturb the sampler, so routing holds.
  property p_pick_hold;
    seen_r && interleave_mode_on && (q[5][1:0] != `CVCFG_PICK_A) && (q[5][1:0] != `CVCFG_PICK_B)
      |=> $stable(cfg.chan_a_takes_b) && $stable(cfg.chan_b_takes_b);
  endproperty
  a_pick_hold: assert property (p_pick_hold) else $error("Reserved pick changed the routing.");

  c_write_fs: cover property (commit && pwrite && (sel == cvcfg_pkg::CVCFG_SEL_FS_A));
  c_read_route: cover property (commit && !pwrite && (sel == cvcfg_pkg::CVCFG_SEL_ROUTE));
  c_unmapped: cover property (commit && pslverr);
  c_interleave_b: cover property (interleave_mode_on && cfg.chan_a_takes_b);
  c_swap_ignored: cover property (interleave_mode_on && $changed(q[5][4]));

endmodule // cvcfg_top
`default_nettype wire

// file: cvcfg_top_tb.sv
// Purpose: Self-checking bench for the converter configuration bank over APB.
// Assumes: Zero-wait-state slave; cfg follows a write one edge after the commit edge.
// Notes: Every bus access checks both read data and the error flag.
`timescale 1ns/100ps
`default_nettype none
`include "cvcfg_map.svh"
module cvcfg_top_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic interleave_mode_on = 1'b0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  cvcfg_pkg::cvcfg_cfg_s cfg;
  int fails = 0;
  int checked = 0;

  cvcfg_top cvcfg_top_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .interleave_mode_on(interleave_mode_on), .cfg(cfg));

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  task report_and_stop;
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp, input logic eerr);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    chk(prdata, exp);
    chk(32'(pslverr), 32'(eerr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  initial
  begin
    logic [11:0] ra [6];
    logic [31:0] rv [6];
    logic [1:0] sw [4];
    logic [2:0] rt [8];
    logic [7:0] rw [8];
    ra = '{`CVCFG_ADDR(`CVCFG_IDX_FS_A), `CVCFG_ADDR(`CVCFG_IDX_FS_B), `CVCFG_ADDR(`CVCFG_IDX_REF),
      `CVCFG_ADDR(`CVCFG_IDX_STAMP), `CVCFG_ADDR(`CVCFG_IDX_SWING), `CVCFG_ADDR(`CVCFG_IDX_ROUTE)};
    rv = '{32'h0000A000, 32'h0000A000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000001};
    sw = '{2'h1, 2'h3, 2'h0, 2'h1};
    // Interleave flag, then expected channel A and channel B source bits.
    rt = '{3'h2, 3'h1, 3'h4, 3'h4, 3'h7, 3'h7, 3'h2, 3'h6};
    rw = '{8'h10, 8'h00, 8'h01, 8'h11, 8'h12, 8'h13, 8'h13, 8'h00};
    @(posedge sys_clk);
    #1;
    chk(32'({cfg.full_scale_code_a, cfg.full_scale_code_b}), 32'hA000A000);
    chk(32'({cfg.reference_bypass, cfg.stamp_receiver_on, cfg.stamp_dc_coupled_mode}), 32'h0);
    chk(32'({cfg.swing_mode, cfg.chan_a_takes_b, cfg.chan_b_takes_b}), 32'h1);
    @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      acc(1'b0, ra[i], 32'h0, rv[i], 1'b0);
    // Boundary codes; the upper half of the bus word is not stored.
    // Calibration runs outside this bench, so only the stored codes are checked after a range change.
    acc(1'b1, ra[0], 32'hFFFF2000, 32'h0, 1'b0);
    acc(1'b1, ra[1], 32'h0000FFFF, 32'h0, 1'b0);
    acc(1'b0, ra[0], 32'h0, 32'h00002000, 1'b0);
    acc(1'b0, ra[1], 32'h0, 32'h0000FFFF, 1'b0);
    settle();
    chk(32'({cfg.full_scale_code_a, cfg.full_scale_code_b}), 32'h2000FFFF);
    acc(1'b1, ra[2], 32'h000001FF, 32'h0, 1'b0);
    acc(1'b0, ra[2], 32'h0, 32'h000000FF, 1'b0);
    settle();
    chk(32'(cfg.reference_bypass), 32'h1);
    for (int v = 1; v < 4; v++)
    begin
      acc(1'b1, ra[3], 32'(v), 32'h0, 1'b0);
      settle();
      chk(32'({cfg.stamp_dc_coupled_mode, cfg.stamp_receiver_on}), 32'(v));
    end
    // The reserved swing code is never written.
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, ra[4], 32'(sw[i]), 32'h0, 1'b0);
      acc(1'b0, ra[4], 32'h0, 32'(sw[i]), 1'b0);
      settle();
      chk(32'(cfg.swing_mode), 32'(sw[i]));
    end
    // Reserved pick codes in interleave leave routing as it was.
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      interleave_mode_on <= rt[i][2];
      acc(1'b1, ra[5], 32'(rw[i]), 32'h0, 1'b0);
      acc(1'b0, ra[5], 32'h0, 32'(rw[i]), 1'b0);
      settle();
      chk(32'({cfg.chan_a_takes_b, cfg.chan_b_takes_b}), 32'(rt[i][1:0]));
    end
    // Unmapped word between the two full-scale codes.
    acc(1'b1, 12'h0C4, 32'h00001234, 32'h0, 1'b1);
    acc(1'b0, 12'h0C4, 32'h0, 32'h0, 1'b1);
    acc(1'b0, ra[0], 32'h0, 32'h00002000, 1'b0);
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(32'(cfg.full_scale_code_a), 32'h0000A000);
    @(posedge sys_clk);
    resetn <= 1'b1;
    acc(1'b0, ra[5], 32'h0, 32'h00000001, 1'b0);
    acc(1'b0, ra[2], 32'h0, 32'h00000000, 1'b0);
    report_and_stop();
  end

  // The sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
endmodule // cvcfg_top_tb
`default_nettype wire
